// File: smc_regs.sv
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - Each input's comparator result reads at its own bit, 1 above threshold, reset zero.
// - With sink derate disable clear, a warning drops 10 or 15 mA sink inputs to 2 mA.
// - With sink derate disable set, sink inputs keep 10 or 15 mA during a warning.
// - Source derate disable at bit 13 does the same for source inputs.
// - The filter field asks for 1, 2, 3 or 4 equal consecutive samples.
// - Interrupt style bit selects static pin assertion at 0, dynamic at 1.
// - Configuration bits 23 to 17 read zero and steer nothing.
// - The run bit starts wetting current and polling; clearing it idles.
module smc_regs (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [smc_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [smc_pkg::REG_W-1:0] reg_wdata,
    output logic [smc_pkg::REG_W-1:0] reg_rdata,
    input wire logic [smc_pkg::NUM_INPUTS-1:0] switch_input_n,
    input wire logic sample_strobe,
    input wire logic temp_warning_event,
    input wire logic [2:0] sink_current_set,
    input wire logic [2:0] source_current_set,
    output logic [2:0] sink_current_out,
    output logic [2:0] source_current_out,
    output logic run_active,
    output logic int_dynamic
);
    logic [smc_pkg::REG_W-1:0] switch_config;
    logic [smc_pkg::REG_W-1:0] next_switch_config;
    logic [smc_pkg::REG_W-1:0] next_rdata;
    logic [smc_pkg::NUM_INPUTS-1:0] in_s1;
    logic [smc_pkg::NUM_INPUTS-1:0] in_s2;
    logic tw_s1;
    logic tw_s2;
    logic [2:0] next_sink;
    logic [2:0] next_source;
    smc_pkg::smc_state_t state;
    smc_pkg::smc_state_t next_state;
    smc_filt_if fi ();

    // Pins are asynchronous to core_clk; two stages before use
    always_ff @(posedge core_clk) begin
        if (rst) begin
            in_s1 <= '0;
            in_s2 <= '0;
            tw_s1 <= 1'b0;
            tw_s2 <= 1'b0;
        end else begin
            in_s1 <= switch_input_n;
            in_s2 <= in_s1;
            tw_s1 <= temp_warning_event;
            tw_s2 <= tw_s1;
        end
    end

    assign fi.raw = in_s2;
    assign fi.depth = switch_config[smc_pkg::BIT_FILT_HI:smc_pkg::BIT_FILT_LO];
    // Samples only count while running
    assign fi.sample_valid = sample_strobe && state == smc_pkg::SMC_RUN;

    smc_filter u_filter (
        .core_clk(core_clk),
        .rst(rst),
        .fi(fi.filt)
    );

    always_comb begin
        next_switch_config = switch_config;
        next_rdata = reg_rdata;
        if (reg_wr && reg_addr == smc_pkg::OFF_SWITCH_CONFIG) begin
            next_switch_config = reg_wdata & smc_pkg::CONFIG_WMASK;
        end
        if (reg_rd) begin
            if (reg_addr == smc_pkg::OFF_COMP_STATE) begin
                next_rdata = fi.filtered;
            end else if (reg_addr == smc_pkg::OFF_SWITCH_CONFIG) begin
                next_rdata = switch_config & smc_pkg::CONFIG_WMASK;
            end else begin
                next_rdata = '0;
            end
        end
    end

    always_comb begin
        next_state = switch_config[smc_pkg::BIT_RUN] ? smc_pkg::SMC_RUN
            : smc_pkg::SMC_IDLE;
        case (state)
            smc_pkg::SMC_IDLE: begin
                next_sink = 3'h0;
                next_source = 3'h0;
            end
            smc_pkg::SMC_RUN: begin
                next_sink = sink_current_set;
                next_source = source_current_set;
                if (tw_s2 && !switch_config[smc_pkg::BIT_DERATE_SINK] &&
                    (sink_current_set == smc_pkg::CUR_10MA ||
                     sink_current_set == smc_pkg::CUR_15MA)) begin
                    next_sink = smc_pkg::CUR_2MA;
                end
                if (tw_s2 && !switch_config[smc_pkg::BIT_DERATE_SOURCE] &&
                    (source_current_set == smc_pkg::CUR_10MA ||
                     source_current_set == smc_pkg::CUR_15MA)) begin
                    next_source = smc_pkg::CUR_2MA;
                end
            end
            default: begin
                next_sink = 3'h0;
                next_source = 3'h0;
            end
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            switch_config <= smc_pkg::CONFIG_RESET;
            reg_rdata <= '0;
            state <= smc_pkg::SMC_IDLE;
            sink_current_out <= 3'h0;
            source_current_out <= 3'h0;
        end else begin
            switch_config <= next_switch_config;
            reg_rdata <= next_rdata;
            state <= next_state;
            sink_current_out <= next_sink;
            source_current_out <= next_source;
        end
    end

    assign run_active = state == smc_pkg::SMC_RUN;
    assign int_dynamic = switch_config[smc_pkg::BIT_INT_STYLE];

    sequence s_cfg_write(logic [23:0] d);
        reg_wr && reg_addr == smc_pkg::OFF_SWITCH_CONFIG && reg_wdata == d;
    endsequence

    AST_RESERVED_ZERO: assert property (@(posedge core_clk) disable iff (rst)
        switch_config[23:17] == 7'h00)
        else $error("reserved config bits set");
    AST_CFG_READBACK: assert property (@(posedge core_clk) disable iff (rst)
        reg_rd && reg_addr == smc_pkg::OFF_SWITCH_CONFIG && !reg_wr
        |=> reg_rdata == (switch_config & smc_pkg::CONFIG_WMASK))
        else $error("config readback wrong");
    AST_COMP_READ: assert property (@(posedge core_clk) disable iff (rst)
        reg_rd && reg_addr == smc_pkg::OFF_COMP_STATE
        |=> reg_rdata == $past(fi.filtered))
        else $error("comparator state read wrong");
    AST_RUN_START: assert property (@(posedge core_clk) disable iff (rst)
        s_cfg_write(reg_wdata) ##0 reg_wdata[smc_pkg::BIT_RUN]
        |=> ##1 run_active)
        else $error("run bit did not start operation");
    AST_RUN_STOP: assert property (@(posedge core_clk) disable iff (rst)
        !switch_config[smc_pkg::BIT_RUN] |=> !run_active ##1
        sink_current_out == 3'h0)
        else $error("device not idle after run cleared");
    AST_SINK_DERATE: assert property (@(posedge core_clk) disable iff (rst)
        run_active && tw_s2 && !switch_config[smc_pkg::BIT_DERATE_SINK] &&
        sink_current_set == smc_pkg::CUR_15MA
        |=> sink_current_out == smc_pkg::CUR_2MA)
        else $error("sink current not derated");
    AST_SINK_KEEP: assert property (@(posedge core_clk) disable iff (rst)
        run_active && switch_config[smc_pkg::BIT_DERATE_SINK]
        |=> sink_current_out == $past(sink_current_set))
        else $error("sink current changed with derate off");
    AST_SOURCE_DERATE: assert property (@(posedge core_clk) disable iff (rst)
        run_active && tw_s2 && !switch_config[smc_pkg::BIT_DERATE_SOURCE] &&
        source_current_set == smc_pkg::CUR_10MA
        |=> source_current_out == smc_pkg::CUR_2MA)
        else $error("source current not derated");
    AST_INT_STYLE: assert property (@(posedge core_clk) disable iff (rst)
        reg_wr && reg_addr == smc_pkg::OFF_SWITCH_CONFIG
        |=> int_dynamic == $past(reg_wdata[smc_pkg::BIT_INT_STYLE]))
        else $error("interrupt style mismatch");
endmodule : smc_regs
`default_nettype wire

// File: smc_pkg.sv
package smc_pkg;
    localparam int NUM_INPUTS = 24;
    localparam int REG_W = 24;
    localparam int ADDR_W = 6;
    localparam logic [5:0] OFF_COMP_STATE = 6'h05;
    localparam logic [5:0] OFF_SWITCH_CONFIG = 6'h1A;
    localparam logic [23:0] CONFIG_RESET = 24'h000000;
    localparam logic [23:0] CONFIG_WMASK = 24'h01FFFF;
    localparam int BIT_DERATE_SINK = 16;
    localparam int BIT_FILT_HI = 15;
    localparam int BIT_FILT_LO = 14;
    localparam int BIT_DERATE_SOURCE = 13;
    localparam int BIT_INT_STYLE = 12;
    localparam int BIT_RUN = 11;
    localparam int CNT_W = 2;
    localparam logic [1:0] CNT_ZERO = 2'h0;
    localparam logic [1:0] CNT_ONE = 2'h1;
    localparam logic [2:0] CUR_2MA = 3'h2;
    localparam logic [2:0] CUR_10MA = 3'h4;
    localparam logic [2:0] CUR_15MA = 3'h5;
    typedef enum logic [0:0] {
        SMC_IDLE = 1'b0,
        SMC_RUN = 1'b1
    } smc_state_t;
endpackage : smc_pkg

// File: smc_filt_if.sv
`timescale 1ns/1ps
`default_nettype none
interface smc_filt_if;
    logic sample_valid;
    logic [1:0] depth;
    logic [smc_pkg::NUM_INPUTS-1:0] raw;
    logic [smc_pkg::NUM_INPUTS-1:0] filtered;
    modport ctrl (output sample_valid, output depth, output raw,
        input filtered);
    modport filt (input sample_valid, input depth, input raw,
        output filtered);
endinterface : smc_filt_if
`default_nettype wire

// File: smc_filter.sv
`timescale 1ns/1ps
`default_nettype none
module smc_filter (
    input wire logic core_clk,
    input wire logic rst,
    smc_filt_if.filt fi
);
    logic [smc_pkg::NUM_INPUTS-1:0] prev;
    logic [smc_pkg::NUM_INPUTS-1:0] next_prev;
    logic [smc_pkg::NUM_INPUTS-1:0] stat;
    logic [smc_pkg::NUM_INPUTS-1:0] next_stat;
    logic [smc_pkg::CNT_W-1:0] cnt [smc_pkg::NUM_INPUTS];
    logic [smc_pkg::CNT_W-1:0] next_cnt [smc_pkg::NUM_INPUTS];
    genvar i;
    generate
        for (i = 0; i < smc_pkg::NUM_INPUTS; i++) begin : g_in
            always_comb begin
                next_prev[i] = prev[i];
                next_stat[i] = stat[i];
                next_cnt[i] = cnt[i];
                if (fi.sample_valid) begin
                    next_prev[i] = fi.raw[i];
                    // Count of equal samples beyond the first
                    // Saturate at depth so a deeper earlier setting never wraps
                    if (fi.raw[i] == prev[i] && cnt[i] < fi.depth) begin
                        next_cnt[i] = cnt[i] + smc_pkg::CNT_ONE;
                    end else if (fi.raw[i] != prev[i]) begin
                        next_cnt[i] = smc_pkg::CNT_ZERO;
                    end
                    // Status holds until the run of equal samples completes
                    if (fi.depth == smc_pkg::CNT_ZERO) begin
                        next_stat[i] = fi.raw[i];
                    end else if (fi.raw[i] == prev[i] &&
                        cnt[i] >= fi.depth - smc_pkg::CNT_ONE) begin
                        next_stat[i] = fi.raw[i];
                    end
                end
            end
            always_ff @(posedge core_clk) begin
                if (rst) begin
                    prev[i] <= 1'b0;
                    stat[i] <= 1'b0;
                    cnt[i] <= smc_pkg::CNT_ZERO;
                end else begin
                    prev[i] <= next_prev[i];
                    stat[i] <= next_stat[i];
                    cnt[i] <= next_cnt[i];
                end
            end
        end
    endgenerate
    assign fi.filtered = stat;

    AST_HOLD_WHEN_IDLE: assert property (@(posedge core_clk) disable iff (rst)
        !fi.sample_valid |=> $stable(stat))
        else $error("filtered status moved without a sample");
    AST_DEPTH0_PASS: assert property (@(posedge core_clk) disable iff (rst)
        fi.sample_valid && fi.depth == smc_pkg::CNT_ZERO
        |=> stat == $past(fi.raw))
        else $error("depth zero did not pass sample through");
endmodule : smc_filter
`default_nettype wire

// File: smc_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module smc_host_model (
    input wire logic core_clk,
    output logic reg_wr,
    output logic reg_rd,
    output logic [smc_pkg::ADDR_W-1:0] reg_addr,
    output logic [smc_pkg::REG_W-1:0] reg_wdata,
    input wire logic [smc_pkg::REG_W-1:0] reg_rdata
);
    initial begin
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 6'h00;
        reg_wdata = 24'h000000;
    end
    // Held over exactly one rising edge; a random idle gap models a slow host
    task automatic access(input logic wr,
            input logic [smc_pkg::ADDR_W-1:0] a,
            input logic [smc_pkg::REG_W-1:0] d,
            output logic [smc_pkg::REG_W-1:0] q);
        repeat ($urandom_range(0, 2)) @(negedge core_clk);
        @(negedge core_clk);
        reg_wr = wr;
        reg_rd = ~wr;
        reg_addr = a;
        reg_wdata = d;
        @(negedge core_clk);
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_wdata = ~d;
        @(negedge core_clk);
        q = reg_rdata;
    endtask : access
endmodule : smc_host_model
`default_nettype wire

// File: testbench.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin n_checks++; if ((got) !== (ex)) begin \
    err_count++; $display("ERROR %s exp %h got %h", nm, ex, got); end end
module testbench;
    logic core_clk, rst, reg_wr, reg_rd, sample_strobe, temp_warning_event;
    logic [5:0] reg_addr;
    logic [23:0] reg_wdata, reg_rdata, switch_input_n, q, old, pat, cfg;
    logic [2:0] sink_current_set, source_current_set, sink_out, source_out;
    logic run_active, int_dynamic, warn;
    int err_count = 0;
    int n_checks = 0;
    smc_regs smc_regs_inst (.core_clk(core_clk), .rst(rst), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .switch_input_n(switch_input_n),
        .sample_strobe(sample_strobe),
        .temp_warning_event(temp_warning_event),
        .sink_current_set(sink_current_set),
        .source_current_set(source_current_set),
        .sink_current_out(sink_out), .source_current_out(source_out),
        .run_active(run_active), .int_dynamic(int_dynamic));
    smc_host_model host_inst (.core_clk(core_clk), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata));
    initial begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end
    function automatic logic [2:0] exp_cur(logic [2:0] s, logic w, logic off,
            logic run);
        if (!run) return 3'h0;
        if (w && !off && (s == smc_pkg::CUR_10MA || s == smc_pkg::CUR_15MA))
            return smc_pkg::CUR_2MA;
        return s;
    endfunction : exp_cur
    // Run is dropped in the same write that loads the new fields; state leaves run a cycle later
    task automatic set_cfg(input logic [23:0] v);
        host_inst.access(1'b1, smc_pkg::OFF_SWITCH_CONFIG, v & 24'hFFF7FF, q);
        host_inst.access(1'b1, smc_pkg::OFF_SWITCH_CONFIG, v, q);
        repeat (4) @(negedge core_clk);
    endtask : set_cfg
    task automatic strobes(input int n);
        repeat (n) begin
            @(negedge core_clk) sample_strobe = 1'b1;
            @(negedge core_clk) sample_strobe = 1'b0;
        end
    endtask : strobes
    task automatic read_comp();
        host_inst.access(1'b0, smc_pkg::OFF_COMP_STATE, 24'h000000, q);
    endtask : read_comp
    task automatic tally_and_finish();
        if (err_count == 0 && n_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : tally_and_finish
    initial begin
        repeat (20000) @(posedge core_clk);
        err_count++;
        tally_and_finish();
    end
    initial begin
        rst = 1'b1;
        sample_strobe = 1'b0;
        temp_warning_event = 1'b0;
        switch_input_n = 24'h000000;
        sink_current_set = 3'h0;
        source_current_set = 3'h0;
        void'($urandom(79));
        repeat (2) @(posedge core_clk);
        @(negedge core_clk) rst = 1'b0;
        host_inst.access(1'b0, smc_pkg::OFF_SWITCH_CONFIG, 24'h000000, q);
        `CHK("config reset", 24'h000000, q)
        read_comp();
        `CHK("status reset", 24'h000000, q)
        set_cfg(24'hFFFDFE);
        host_inst.access(1'b0, smc_pkg::OFF_SWITCH_CONFIG, 24'h000000, q);
        `CHK("config mask", 24'h01FDFE, q)
        `CHK("int style", 1'b1, int_dynamic)
        host_inst.access(1'b1, smc_pkg::OFF_COMP_STATE, 24'hFFFFFF, q);
        read_comp();
        `CHK("status ro", 24'h000000, q)
        host_inst.access(1'b0, 6'h3F, 24'h000000, q);
        `CHK("unmapped", 24'h000000, q)
        for (int i = 0; i < 24; i++) begin
            cfg = $urandom & 24'h013800;
            sink_current_set = (i < 2) ? smc_pkg::CUR_15MA : 3'($urandom);
            source_current_set = (i < 2) ? smc_pkg::CUR_10MA : 3'($urandom);
            warn = (i < 4) ? 1'b1 : 1'($urandom);
            temp_warning_event = warn;
            set_cfg(cfg);
            `CHK("run", cfg[11], run_active)
            `CHK("int style", cfg[12], int_dynamic)
            `CHK("sink", exp_cur(sink_current_set, warn, cfg[16], cfg[11]), sink_out)
            `CHK("source", exp_cur(source_current_set, warn, cfg[13], cfg[11]), source_out)
        end
        old = 24'h000000;
        for (int i = 0; i < 8; i++) begin
            set_cfg(24'(i % 4) << 14 | 24'h000800);
            strobes(1);
            pat = $urandom;
            switch_input_n = pat;
            repeat (3) @(negedge core_clk);
            strobes(i % 4);
            read_comp();
            `CHK("status hold", old, q)
            strobes(1);
            read_comp();
            `CHK("status new", pat, q)
            old = pat;
        end
        tally_and_finish();
    end
endmodule : testbench
`default_nettype wire
